// [tve_map.svh]
// Constant map of the video encoder timing and subcarrier register set.
`ifndef TVE_MAP_SVH
`define TVE_MAP_SVH
// Behaviour
// - One bit selects timing master or slave.
// - Two bits select the video timing mode.
// - Slave mode: bit honours or ignores blank input.
// - Two bits add luma delay, 74 ns each; code rounds each step up to 19 clocks, 76 ns.
// - Host always writes zero to pixel format.
// - Low-high-low on reset bit restarts timing counters.
// - Host pulses timing reset after reset, mode change.
// - Master mode: two bits set hsync width.
// - Two bits shift hsync against field/vsync.
// - Mode 1: shared field positions hsync versus field.
// - Mode 2: shared field sets vsync width.
// - Two bits shift hsync against pixel data.
// - Software computes increment from cycles per line.
// - Frequency byte zero resets 16h; host writes 1E.
// - Phase register offsets subcarrier, 1.41 degrees per step.
// - Two bytes hold even field caption data.
// - Two bytes hold odd field caption data.
// - NTSC: line bits switch pedestal off per line.
// - PAL: line bits enable teletext per line.
// - Four bits place teletext request rise, 0-15.
// - Four bits place teletext request fall, 0-15.
// - Fall field zero: fall tracks rise, length kept.

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define TVE_OFS_TR0       5'h07
`define TVE_OFS_TR1       5'h08
`define TVE_OFS_SUBCARRIER_FREQ_BYTE0      5'h09
`define TVE_OFS_SUBCARRIER_FREQ_BYTE3      5'h0C
`define TVE_OFS_PHASE     5'h0D
`define TVE_OFS_CCE0      5'h0E
`define TVE_OFS_CCO0      5'h10
`define TVE_OFS_LEN0      5'h12
`define TVE_OFS_LEN3      5'h15
`define TVE_OFS_TTXC      5'h19
`define TVE_REG_COUNT     19
`define TVE_SUBCARRIER_FREQ_BYTE0_RESET    8'h16
`define TVE_SUBCARRIER_FREQ_BYTE0_NTSC     8'h1E

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define TVE_TR0_MASTER    0
`define TVE_TR0_MODE      1
`define TVE_TR0_BLANK     3
`define TVE_TR0_LUMA      4
`define TVE_TR0_PIXFMT    6
`define TVE_TR0_TRESET    7
`define TVE_TR1_HSW       0
`define TVE_TR1_HSV       2
`define TVE_TR1_FEV       4
`define TVE_TR1_ALIGN     6
`define TVE_TTX_FALL      0
`define TVE_TTX_RISE      4

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define TVE_CLK_PS        4000
`define TVE_LUMA_STEP_PS  74000
`define TVE_LINE_CLKS     1716
`define TVE_FRAME_LINES   525
`define TVE_HS_W_BASE     11'h040
`define TVE_HS_W_STEP     11'h010
`define TVE_HS_POS_STEP   11'h004
`define TVE_VS_LINES      10'h003
`define TVE_VBI_FIRST     10'h007
`define TVE_VBI_LINES     10'h010
`define TVE_ACTIVE_START  11'h0F4
`define TVE_TTX_BASE      11'h0C8
`define TVE_TTX_WINDOW    11'h578

// ----------------------------------------------------------------------
// Host controller registers
// ----------------------------------------------------------------------
`define TVE_H_TGT         4'h0
`define TVE_H_DATA        4'h1
`define TVE_H_CTRL        4'h2
`define TVE_H_STAT        4'h3
`define TVE_H_RDATA       4'h4
`endif

// [tve_pkg.sv]
// Types shared by both ends of the video encoder register link.
`include "tve_map.svh"
package tve_pkg;
    localparam int LD_STEP  = (`TVE_LUMA_STEP_PS + `TVE_CLK_PS - 1) / `TVE_CLK_PS;
    localparam int LD_DEPTH = 3 * LD_STEP + 1;

    typedef enum logic [1:0] {TVE_MODE0, TVE_MODE1, TVE_MODE2, TVE_MODE3} tve_mode_e;

    typedef struct packed {
        logic [`TVE_REG_COUNT-1:0][7:0] regs;
        logic [LD_DEPTH-1:0][7:0]       ldly;
        logic                           treset_prev;
        logic                           ext_hs_prev;
        logic                           ext_vs_prev;
        logic [10:0]                    hcnt;
        logic [9:0]                     vcnt;
        logic [31:0]                    acc;
        logic [2:0]                     hs_pipe;
        logic [7:0]                     rdata;
        logic [7:0]                     sc_phase;
        logic [7:0]                     luma_out;
        logic [15:0]                    caption_word;
        logic                           hsync_n;
        logic                           vsync_n;
        logic                           field;
        logic                           blank_n;
        logic                           ttx_req;
        logic                           ped_off;
        logic                           ttx_line;
    } tve_dev_s;

    typedef enum logic [2:0] {H_INIT_FSC, H_TR_HI, H_TR_LO, H_IDLE, H_RWAIT} tve_host_e;

    typedef struct packed {
        tve_host_e  state;
        logic [4:0] tgt;
        logic [7:0] data;
        logic [7:0] tr0;
        logic [7:0] rdata;
        logic [7:0] sw_rdata;
        logic [4:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } tve_host_s;
endpackage

// [tve_link_if.sv]
// Register link between the encoder host and the encoder register set.
`timescale 1ns/10ps
interface tve_link_if;
    logic [4:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic [7:0] rdata;

    modport host (output addr, output wdata, output wr, output rd, input rdata);
    modport dev  (input addr, input wdata, input wr, input rd, output rdata);
endinterface

// [tve_dev.sv]
// Encoder register set with timing generator, subcarrier and teletext request.
`timescale 1ns/10ps
module tve_dev
    import tve_pkg::*;
#(
    parameter int LINE_CLKS   = `TVE_LINE_CLKS,
    parameter int FRAME_LINES = `TVE_FRAME_LINES
) (
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    tve_link_if.dev          lnk,
    input  wire logic        video_is_pal,
    input  wire logic        ext_hsync_n,
    input  wire logic        ext_vsync_n,
    input  wire logic        ext_blank_n,
    input  wire logic [7:0]  luma_in,
    output logic             hsync_out_n,
    output logic             vsync_out_n,
    output logic             field_out,
    output logic             blank_out_n,
    output logic             teletext_request,
    output logic             pedestal_off,
    output logic             teletext_line,
    output logic [7:0]       subcarrier_phase_out,
    output logic [7:0]       luma_out,
    output logic [15:0]      caption_word
);
    tve_dev_s q;
    tve_dev_s n;

    localparam logic [10:0] LINE_LAST  = 11'(LINE_CLKS - 1);
    localparam logic [9:0]  FRAME_LAST = 10'(FRAME_LINES - 1);
    localparam logic [9:0]  HALF_LINES = 10'(FRAME_LINES / 2);

    // ------------------------------------------------------------------
    // Register access and timing generation
    // ------------------------------------------------------------------
    logic        mapped;
    logic [4:0]  idx;
    logic [7:0]  tr0;
    logic [7:0]  tr1;
    logic [7:0]  ttxc;
    logic        master;
    logic        restart;
    tve_mode_e   mode;
    logic [10:0] hs_pos;
    logic [10:0] hs_wid;
    logic [9:0]  vs_len;
    logic [9:0]  fline;
    logic [9:0]  lidx;
    logic        in_vbi;
    logic [15:0] lbits;
    logic        hs_int;
    logic        int_blank_n;
    logic [10:0] rise_at;
    logic [10:0] fall_at;
    logic [31:0] inc;
    logic [1:0]  align;
    logic [1:0]  lsteps;

    always_comb begin
        n       = q;
        idx     = lnk.addr - `TVE_OFS_TR0;
        mapped  = (lnk.addr >= `TVE_OFS_TR0 && lnk.addr <= `TVE_OFS_LEN3)
                  || lnk.addr == `TVE_OFS_TTXC;
        if (lnk.addr == `TVE_OFS_TTXC) begin
            idx = 5'(`TVE_REG_COUNT - 1);
        end
        n.rdata = 8'h00;
        if (lnk.rd && mapped) begin
            n.rdata = q.regs[idx];
        end
        if (lnk.wr && mapped) begin
            n.regs[idx] = lnk.wdata;
        end

        tr0     = q.regs[`TVE_OFS_TR0 - `TVE_OFS_TR0];
        tr1     = q.regs[`TVE_OFS_TR1 - `TVE_OFS_TR0];
        ttxc    = q.regs[`TVE_REG_COUNT - 1];
        master  = tr0[`TVE_TR0_MASTER];
        mode    = tve_mode_e'(tr0[`TVE_TR0_MODE +: 2]);
        align   = tr1[`TVE_TR1_ALIGN +: 2];
        lsteps  = tr0[`TVE_TR0_LUMA +: 2];
        inc     = {q.regs[`TVE_OFS_SUBCARRIER_FREQ_BYTE3 - `TVE_OFS_TR0], q.regs[`TVE_OFS_SUBCARRIER_FREQ_BYTE0 + 5'h02 - `TVE_OFS_TR0],
                   q.regs[`TVE_OFS_SUBCARRIER_FREQ_BYTE0 + 5'h01 - `TVE_OFS_TR0], q.regs[`TVE_OFS_SUBCARRIER_FREQ_BYTE0 - `TVE_OFS_TR0]};

        // Counters restart when the reset bit falls after having been high.
        n.treset_prev = tr0[`TVE_TR0_TRESET];
        restart       = q.treset_prev && !tr0[`TVE_TR0_TRESET];
        n.ext_hs_prev = ext_hsync_n;
        n.ext_vs_prev = ext_vsync_n;
        if (restart || (!master && q.ext_hs_prev && !ext_hsync_n)) begin
            n.hcnt = 11'h000;
            if (restart || (!master && !ext_vsync_n && q.ext_vs_prev)) begin
                n.vcnt = 10'h000;
            end
        end else if (q.hcnt == LINE_LAST) begin
            n.hcnt = 11'h000;
            n.vcnt = (q.vcnt == FRAME_LAST) ? 10'h000 : q.vcnt + 10'h001;
        end else begin
            n.hcnt = q.hcnt + 11'h001;
        end

        // Master hsync position and width.
        hs_pos = 11'(tr1[`TVE_TR1_HSV +: 2]) * `TVE_HS_POS_STEP;
        if (mode == TVE_MODE1) begin
            hs_pos = hs_pos + 11'(tr1[`TVE_TR1_FEV +: 2]) * `TVE_HS_POS_STEP;
        end
        hs_wid = `TVE_HS_W_BASE + 11'(tr1[`TVE_TR1_HSW +: 2]) * `TVE_HS_W_STEP;
        vs_len = `TVE_VS_LINES;
        if (mode == TVE_MODE2) begin
            vs_len = `TVE_VS_LINES + 10'(tr1[`TVE_TR1_FEV +: 2]);
        end
        n.field  = q.vcnt >= HALF_LINES;
        fline    = n.field ? q.vcnt - HALF_LINES : q.vcnt;
        n.vsync_n = master ? !(fline < vs_len) : ext_vsync_n;
        hs_int   = master ? !(q.hcnt >= hs_pos && q.hcnt < hs_pos + hs_wid) : ext_hsync_n;
        n.hs_pipe = {q.hs_pipe[1:0], hs_int};
        n.hsync_n = (align == 2'h0) ? hs_int : q.hs_pipe[align - 2'h1];

        // Blanking and per-line enables.
        lidx   = fline - `TVE_VBI_FIRST;
        in_vbi = fline >= `TVE_VBI_FIRST && fline < `TVE_VBI_FIRST + `TVE_VBI_LINES;
        int_blank_n = (q.hcnt >= `TVE_ACTIVE_START) && !in_vbi && fline >= `TVE_VBI_FIRST;
        n.blank_n = (!master && tr0[`TVE_TR0_BLANK]) ? ext_blank_n : int_blank_n;
        lbits = n.field ? {q.regs[`TVE_OFS_LEN0 + 5'h01 - `TVE_OFS_TR0],
                           q.regs[`TVE_OFS_LEN0 - `TVE_OFS_TR0]}
                        : {q.regs[`TVE_OFS_LEN3 - `TVE_OFS_TR0],
                           q.regs[`TVE_OFS_LEN3 - 5'h01 - `TVE_OFS_TR0]};
        n.ped_off  = !video_is_pal && in_vbi && lbits[lidx[3:0]];
        n.ttx_line = video_is_pal && in_vbi && lbits[lidx[3:0]];

        // Teletext request window.
        rise_at = `TVE_TTX_BASE + 11'(ttxc[`TVE_TTX_RISE +: 4]);
        if (ttxc[`TVE_TTX_FALL +: 4] == 4'h0) begin
            fall_at = rise_at + `TVE_TTX_WINDOW;
        end else begin
            fall_at = `TVE_TTX_BASE + `TVE_TTX_WINDOW - 11'(ttxc[`TVE_TTX_FALL +: 4]);
        end
        n.ttx_req = n.ttx_line && q.hcnt >= rise_at && q.hcnt < fall_at;

        // Subcarrier synthesis, captions and luma delay.
        n.acc      = restart ? 32'h0000_0000 : q.acc + inc;
        n.sc_phase = q.acc[31:24] + q.regs[`TVE_OFS_PHASE - `TVE_OFS_TR0];
        n.caption_word = n.field
            ? {q.regs[`TVE_OFS_CCE0 + 5'h01 - `TVE_OFS_TR0], q.regs[`TVE_OFS_CCE0 - `TVE_OFS_TR0]}
            : {q.regs[`TVE_OFS_CCO0 + 5'h01 - `TVE_OFS_TR0], q.regs[`TVE_OFS_CCO0 - `TVE_OFS_TR0]};
        n.ldly     = {q.ldly[LD_DEPTH-2:0], luma_in};
        n.luma_out = q.ldly[32'(lsteps) * LD_STEP];
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            q <= '0;
            q.regs[`TVE_OFS_SUBCARRIER_FREQ_BYTE0 - `TVE_OFS_TR0] <= `TVE_SUBCARRIER_FREQ_BYTE0_RESET;
            q.hsync_n <= 1'b1;
            q.vsync_n <= 1'b1;
            q.hs_pipe <= 3'h7;
            q.ext_hs_prev <= 1'b1;
            q.ext_vs_prev <= 1'b1;
        end else begin
            q <= n;
        end
    end

    assign lnk.rdata            = q.rdata;
    assign hsync_out_n          = q.hsync_n;
    assign vsync_out_n          = q.vsync_n;
    assign field_out            = q.field;
    assign blank_out_n          = q.blank_n;
    assign teletext_request     = q.ttx_req;
    assign pedestal_off         = q.ped_off;
    assign teletext_line        = q.ttx_line;
    assign subcarrier_phase_out = q.sc_phase;
    assign luma_out             = q.luma_out;
    assign caption_word         = q.caption_word;
endmodule

// [tve_host.sv]
// Host end that programs the encoder registers on behalf of software.
`timescale 1ns/10ps
module tve_host
    import tve_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    input  wire logic [3:0]  sw_addr,
    input  wire logic [7:0]  sw_wdata,
    input  wire logic        sw_wr,
    input  wire logic        sw_rd,
    output logic [7:0]       sw_rdata,
    tve_link_if.host         lnk
);
    tve_host_s q;
    tve_host_s n;

    localparam logic [7:0] PIX_MASK = 8'h01 << `TVE_TR0_PIXFMT;
    localparam logic [7:0] TRS_MASK = 8'h01 << `TVE_TR0_TRESET;

    // ------------------------------------------------------------------
    // Command sequencing
    // ------------------------------------------------------------------
    always_comb begin
        n          = q;
        n.wr       = 1'b0;
        n.rd       = 1'b0;
        n.sw_rdata = 8'h00;
        if (sw_wr && sw_addr == `TVE_H_TGT) begin
            n.tgt = sw_wdata[4:0];
        end
        if (sw_wr && sw_addr == `TVE_H_DATA) begin
            n.data = sw_wdata;
        end
        if (sw_rd) begin
            case (sw_addr)
                `TVE_H_TGT:   n.sw_rdata = {3'h0, q.tgt};
                `TVE_H_DATA:  n.sw_rdata = q.data;
                `TVE_H_STAT:  n.sw_rdata = {7'h00, q.state != H_IDLE};
                `TVE_H_RDATA: n.sw_rdata = q.rdata;
                default:      n.sw_rdata = 8'h00;
            endcase
        end
        case (q.state)
            H_INIT_FSC: begin
                n.wr    = 1'b1;
                n.addr  = `TVE_OFS_SUBCARRIER_FREQ_BYTE0;
                n.wdata = `TVE_SUBCARRIER_FREQ_BYTE0_NTSC;
                n.state = H_TR_HI;
            end
            H_TR_HI: begin
                n.wr    = 1'b1;
                n.addr  = `TVE_OFS_TR0;
                n.wdata = (q.tr0 & ~PIX_MASK) | TRS_MASK;
                n.state = H_TR_LO;
            end
            H_TR_LO: begin
                n.wr    = 1'b1;
                n.addr  = `TVE_OFS_TR0;
                n.wdata = q.tr0 & ~PIX_MASK & ~TRS_MASK;
                n.state = H_IDLE;
            end
            H_IDLE: begin
                if (sw_wr && sw_addr == `TVE_H_CTRL && sw_wdata[0]) begin
                    if (q.tgt == `TVE_OFS_TR0) begin
                        n.tr0   = q.data & ~PIX_MASK & ~TRS_MASK;
                        n.state = H_TR_HI;
                    end else begin
                        n.wr    = 1'b1;
                        n.addr  = q.tgt;
                        n.wdata = q.data;
                    end
                end else if (sw_wr && sw_addr == `TVE_H_CTRL && sw_wdata[1]) begin
                    n.rd    = 1'b1;
                    n.addr  = q.tgt;
                    n.state = H_RWAIT;
                end
            end
            H_RWAIT: begin
                if (!q.rd) begin
                    n.rdata = lnk.rdata;
                    n.state = H_IDLE;
                end
            end
            default: begin
                n.state = H_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            q       <= '0;
            q.state <= H_INIT_FSC;
        end else begin
            q <= n;
        end
    end

    assign sw_rdata  = q.sw_rdata;
    assign lnk.addr  = q.addr;
    assign lnk.wdata = q.wdata;
    assign lnk.wr    = q.wr;
    assign lnk.rd    = q.rd;
endmodule

// [tve_link_props.sv]
// Concurrent checks on the link between the encoder host and the register set.
`timescale 1ns/10ps
`include "tve_map.svh"
module tve_link_props (
    input wire logic       ref_clk,
    input wire logic       reset_n,
    input wire logic [4:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [7:0] rdata
);
    // ------------------------------------------------------------------
    // Shadow of the register contents
    // ------------------------------------------------------------------
    logic [7:0] shadow_q [0:31];
    logic [7:0] want_q;
    logic       mapped;

    assign mapped = ((addr >= `TVE_OFS_TR0) && (addr <= `TVE_OFS_LEN3)) || (addr == `TVE_OFS_TTXC);

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < 32; i++) begin
                shadow_q[i] <= (i == 9) ? `TVE_SUBCARRIER_FREQ_BYTE0_RESET : 8'h00;
            end
            want_q <= 8'h00;
        end else begin
            if (wr && mapped) begin
                shadow_q[addr] <= wdata;
            end
            want_q <= mapped ? shadow_q[addr] : 8'h00;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);

    AST_NO_WR_RD: assert property (!(wr && rd))
        else $error("link write and read strobes high together");
    AST_READBACK: assert property (rd |=> rdata == want_q)
        else $error("link read data differs from last written value");
    AST_RDATA_IDLE: assert property (!rd |=> rdata == 8'h00)
        else $error("link read data not zero outside read answer");
    AST_UNMAPPED: assert property (rd && !mapped |=> rdata == 8'h00)
        else $error("unmapped offset returned nonzero data");
    AST_PIXFMT: assert property (wr && addr == `TVE_OFS_TR0 |-> !wdata[6])
        else $error("pixel port format bit written as one");
    AST_TRESET_PAIR: assert property (wr && addr == `TVE_OFS_TR0 && wdata[7]
        |=> wr && addr == `TVE_OFS_TR0 && wdata == ($past(wdata) & 8'h7F))
        else $error("timing reset high write not followed by low write");
    AST_TRESET_LEAD: assert property (wr && addr == `TVE_OFS_TR0 && !wdata[7]
        |-> $past(wr && addr == `TVE_OFS_TR0 && wdata[7]))
        else $error("timing control write without preceding reset pulse");
    AST_INIT_FSC: assert property ($rose(reset_n)
        |-> ##[0:3] (wr && addr == `TVE_OFS_SUBCARRIER_FREQ_BYTE0 && wdata == `TVE_SUBCARRIER_FREQ_BYTE0_NTSC))
        else $error("frequency byte zero not rewritten after reset");

    cover property (wr && addr == `TVE_OFS_TR0 && wdata[7]);
    cover property (rd && !mapped);
    cover property (rd && addr == `TVE_OFS_SUBCARRIER_FREQ_BYTE0);
endmodule

// [test_video_encoder_timing_subcarrier_regs.sv]
// Self-checking bench for the encoder host and register set joined by the link.
`timescale 1ns/10ps
module test_video_encoder_timing_subcarrier_regs;
    import tve_pkg::*;
    typedef enum logic [1:0] {K_REG, K_LUMA, K_HSW, K_TTX} tve_kind_e;
    typedef struct packed {
        tve_kind_e   kind;
        logic [4:0]  tgt;
        logic [7:0]  data;
        logic [15:0] want;
    } tve_row_s;

    logic        ref_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic [3:0]  sw_addr = 4'h0;
    logic [7:0]  sw_wdata = 8'h00;
    logic        sw_wr = 1'b0;
    logic        sw_rd = 1'b0;
    logic [7:0]  sw_rdata;
    logic        ext_blank_n = 1'b1;
    logic [7:0]  lcnt_q = 8'h00;
    logic        hsync_out_n, vsync_out_n, field_out, blank_out_n;
    logic        teletext_request, pedestal_off, teletext_line;
    logic [7:0]  subcarrier_phase_out, luma_out, rv, p0;
    logic [15:0] caption_word;
    int          err_count = 0;
    int          total_checks = 0;
    int          n;
    tve_row_s    rows [26] = '{
        '{K_REG, 5'h08, 8'hA5, 16'h00A5}, '{K_REG, 5'h0D, 8'h3C, 16'h003C},
        '{K_REG, 5'h0E, 8'h11, 16'h0011}, '{K_REG, 5'h0F, 8'h22, 16'h0022},
        '{K_REG, 5'h10, 8'h33, 16'h0033}, '{K_REG, 5'h11, 8'h44, 16'h0044},
        '{K_REG, 5'h12, 8'hFF, 16'h00FF}, '{K_REG, 5'h13, 8'hFF, 16'h00FF},
        '{K_REG, 5'h14, 8'hFF, 16'h00FF}, '{K_REG, 5'h15, 8'hFF, 16'h00FF},
        '{K_REG, 5'h19, 8'h00, 16'h0000}, '{K_REG, 5'h16, 8'h5A, 16'h0000},
        '{K_REG, 5'h0C, 8'h21, 16'h0021}, '{K_REG, 5'h07, 8'h45, 16'h0005},
        '{K_LUMA, 5'h07, 8'h01, 16'(1)}, '{K_LUMA, 5'h07, 8'h11, 16'(1 + LD_STEP)},
        '{K_LUMA, 5'h07, 8'h21, 16'(1 + 2 * LD_STEP)},
        '{K_LUMA, 5'h07, 8'h31, 16'(1 + 3 * LD_STEP)},
        '{K_HSW, 5'h08, 8'h00, 16'h0040}, '{K_HSW, 5'h08, 8'h01, 16'h0050},
        '{K_HSW, 5'h08, 8'h02, 16'h0060}, '{K_HSW, 5'h08, 8'h03, 16'h0070},
        '{K_TTX, 5'h19, 8'h50, 16'h0578}, '{K_TTX, 5'h19, 8'hA0, 16'h0578},
        '{K_TTX, 5'h19, 8'h53, 16'h0570}, '{K_TTX, 5'h19, 8'h0F, 16'h0569}};

    tve_link_if tve_link_if_inst ();

    tve_host tve_host_inst (.ref_clk(ref_clk), .reset_n(reset_n), .sw_addr(sw_addr),
        .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata),
        .lnk(tve_link_if_inst.host));

    tve_dev tve_dev_inst (.ref_clk(ref_clk), .reset_n(reset_n), .lnk(tve_link_if_inst.dev),
        .video_is_pal(1'b1), .ext_hsync_n(1'b1), .ext_vsync_n(1'b1),
        .ext_blank_n(ext_blank_n), .luma_in(lcnt_q), .hsync_out_n(hsync_out_n),
        .vsync_out_n(vsync_out_n), .field_out(field_out), .blank_out_n(blank_out_n),
        .teletext_request(teletext_request), .pedestal_off(pedestal_off),
        .teletext_line(teletext_line), .subcarrier_phase_out(subcarrier_phase_out),
        .luma_out(luma_out), .caption_word(caption_word));

    tve_link_props tve_link_props_inst (.ref_clk(ref_clk), .reset_n(reset_n),
        .addr(tve_link_if_inst.addr), .wdata(tve_link_if_inst.wdata),
        .wr(tve_link_if_inst.wr), .rd(tve_link_if_inst.rd), .rdata(tve_link_if_inst.rdata));

    always #2 ref_clk = ~ref_clk;

    always @(posedge ref_clk) begin
        lcnt_q <= lcnt_q + 8'h01;
    end

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic chkv(input string what, input logic [15:0] want, input logic [15:0] got);
        total_checks++;
        if (got !== want) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, want, got);
        end
    endtask

    task automatic chkn(input string what, input int want, input int got);
        total_checks++;
        if (got != want) begin
            err_count++;
            $display("BAD %s expected %0d seen %0d", what, want, got);
        end
    endtask

    task automatic sw_op(input logic w, input logic r, input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        sw_wr <= w;
        sw_rd <= r;
        sw_addr <= a;
        sw_wdata <= d;
    endtask

    task automatic sw_read(input logic [3:0] a, output logic [7:0] v);
        sw_op(1'b0, 1'b1, a, 8'h00);
        sw_op(1'b0, 1'b0, 4'h0, 8'h00);
        #1 v = sw_rdata;
    endtask

    task automatic wait_idle;
        logic [7:0] s;
        for (int k = 0; k < 50; k++) begin
            sw_read(4'h3, s);
            if (s[0] === 1'b0) break;
        end
    endtask

    task automatic reg_wr(input logic [4:0] t, input logic [7:0] d);
        sw_op(1'b1, 1'b0, 4'h0, {3'h0, t});
        sw_op(1'b1, 1'b0, 4'h1, d);
        sw_op(1'b1, 1'b0, 4'h2, 8'h01);
        sw_op(1'b0, 1'b0, 4'h0, 8'h00);
        wait_idle();
    endtask

    task automatic reg_rd(input logic [4:0] t, output logic [7:0] v);
        sw_op(1'b1, 1'b0, 4'h0, {3'h0, t});
        sw_op(1'b1, 1'b0, 4'h2, 8'h02);
        sw_op(1'b0, 1'b0, 4'h0, 8'h00);
        wait_idle();
        sw_read(4'h4, v);
    endtask

    function automatic logic probe(input logic hs);
        return hs ? !hsync_out_n : teletext_request;
    endfunction

    task automatic measure(input logic hs, output int cnt);
        int w;
        cnt = 0;
        w = 0;
        while (probe(hs) !== 1'b0 && w < 40000) begin
            @(posedge ref_clk);
            #1 w++;
        end
        while (probe(hs) !== 1'b1 && w < 40000) begin
            @(posedge ref_clk);
            #1 w++;
        end
        while (probe(hs) === 1'b1 && cnt < 40000) begin
            @(posedge ref_clk);
            #1 cnt++;
        end
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (95000) @(posedge ref_clk);
        err_count++;
        complete_run();
    end

    initial begin
        repeat (12) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (8) @(posedge ref_clk);
        foreach (rows[i]) begin
            reg_wr(rows[i].tgt, rows[i].data);
            case (rows[i].kind)
                K_REG: begin
                    reg_rd(rows[i].tgt, rv);
                    chkv("register", rows[i].want, {8'h00, rv});
                end
                K_LUMA: begin
                    repeat (70) @(posedge ref_clk);
                    #1 chkv("luma", {8'h00, 8'(lcnt_q - 8'h01 - rows[i].want[7:0])},
                        {8'h00, luma_out});
                end
                default: begin
                    measure(rows[i].kind == K_HSW, n);
                    chkn("pulse width", int'(rows[i].want), n);
                    if (rows[i].kind == K_TTX) begin
                        chkv("teletext line", 16'h0001, {15'h0, teletext_line});
                        chkv("pedestal", 16'h0000, {15'h0, pedestal_off});
                    end
                end
            endcase
        end
        chkv("caption", 16'h4433, caption_word);
        chkv("field", 16'h0000, {15'h0, field_out});
        chkv("vsync", 16'h0001, {15'h0, vsync_out_n});
        reg_wr(5'h09, 8'h00);
        reg_wr(5'h0C, 8'h01);
        @(posedge ref_clk);
        #1 p0 = subcarrier_phase_out;
        @(posedge ref_clk);
        #1 chkv("phase step", 16'h0001, {8'h00, 8'(subcarrier_phase_out - p0)});
        @(posedge ref_clk);
        reset_n <= 1'b0;
        repeat (3) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (8) @(posedge ref_clk);
        reg_rd(5'h09, rv);
        chkv("freq byte0", 16'h001E, {8'h00, rv});
        reg_rd(5'h0D, rv);
        chkv("phase reset", 16'h0000, {8'h00, rv});
        ext_blank_n <= 1'b0;
        reg_wr(5'h07, 8'h08);
        repeat (10) @(posedge ref_clk);
        #1 chkv("blank", 16'h0000, {15'h0, blank_out_n});
        complete_run();
    end
endmodule
